// [shared/tmr16_cfg.svh]
// Offsets, field positions, reset values and clock settings of the timer.
`ifndef TMR16_CFG_SVH
`define TMR16_CFG_SVH
`define OFF_LOWER_CTRL 12'h000
`define OFF_UPPER_CTRL 12'h004
`define OFF_CMP_LOW 12'h008
`define OFF_CMP_HIGH 12'h00C
`define OFF_DUTY_LOW 12'h010
`define OFF_DUTY_HIGH 12'h014
`define OFF_STATUS 12'h018
`define OFF_COUNT 12'h01C
`define OFF_SYSCFG 12'h020
`define UC_RUN_BIT 3
`define UC_INIT_BIT 7
`define UC_MODE_LSB 0
`define LC_CLK_LSB 4
`define LC_MODE_LSB 0
`define MODE_TIMER16 3'h4
`define MODE_PWM16 3'h6
`define RST_UPPER_CTRL 8'h00
`define RST_LOWER_CTRL 8'h00
`define HF_PER_NS 62.5
`define CLK_PER_NS 4.0
`define LF_DIV_DEFAULT 7629
`endif

// [shared/tmr16_pkg.sv]
// Types shared by the cascaded timer files.
package tmr16_pkg;
   typedef enum logic [1:0] {
      OP_STOPPED,
      OP_TIMER,
      OP_PWM
   } op_mode_t;
endpackage

// [src/tmr16_prescaler.sv]
// Prescaler that turns the system clock into one-cycle source enables.
`timescale 1ns/1ps
`include "tmr16_cfg.svh"
module tmr16_prescaler
   #(parameter int HF_DIV = 16,
     parameter int LF_DIV = `LF_DIV_DEFAULT)
   (input wire logic clk,
    input wire logic rst_n,
    output logic [11:0] hf_tick,
    output logic lf_tick,
    output logic lf8_tick);
   // ************************************************************
   // High-frequency chain
   // ************************************************************
   logic [$clog2(HF_DIV)-1:0] base_q;
   logic [11:0] chain_q;
   logic hf_base;
   logic [15:0] lf_cnt_q;
   logic [2:0] lf8_q;
   assign hf_base = (base_q == $bits(base_q)'(HF_DIV - 1));
   // Base divider emulates the 16 MHz machine clock from the 250 MHz clock.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         base_q <= '0;
         chain_q <= 12'h000;
      end
      else
      begin
         base_q <= hf_base ? '0 : base_q + 1'b1;
         if (hf_base)
            chain_q <= chain_q + 12'h001;
      end
   end
   // Bit n pulses once every 2^n high clocks; the all-ones test avoids glitches.
   genvar g;
   generate
      for (g = 0; g < 12; g++)
      begin : g_tick
         if (g == 0)
            assign hf_tick[g] = hf_base;
         else
            assign hf_tick[g] = hf_base && (&chain_q[g-1:0]);
      end
   endgenerate
   // ************************************************************
   // Low-frequency chain
   // ************************************************************
   // The low clock is derived here, so it is only as exact as LF_DIV allows.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lf_cnt_q <= 16'h0000;
         lf8_q <= 3'h0;
      end
      else if (lf_cnt_q == 16'(LF_DIV - 1))
      begin
         lf_cnt_q <= 16'h0000;
         lf8_q <= lf8_q + 3'h1;
      end
      else
         lf_cnt_q <= lf_cnt_q + 16'h0001;
   end
   assign lf_tick = (lf_cnt_q == 16'(LF_DIV - 1));
   assign lf8_tick = lf_tick && (lf8_q == 3'h7);
endmodule

// [src/tmr16_timer.sv]
// Cascaded 16-bit timer and PWM generator with an APB register slave.
// How it works
// - Lower and upper units form one 16-bit up-counter on the source tick.
// - Once running, count equal to compare raises interrupt, clears, continues.
// - Timer-mode compare has no shadow; writes act at once.
// - Timer clocks are high/2^11, 2^7, 2^5, 2^3; slowest may be low/2^3.
// - PWM duty match toggles flip-flop; overflow toggles, clears, interrupts.
// - Flip-flop loads from the initial-value bit; reset clears it.
// - PWM pin drives the inverse of the flip-flop.
// - Running duty writes wait in shadow until interrupt; stopped, immediate.
// - Duty reads while running give the active value.
// - Stopping holds the pin; a later initial-bit write changes it.
// - PWM adds high clock, high/2 and low clock; period 2^16 ticks.
// - Upper control bit 3 is run, bit 7 is the initial-value bit.
// - Writing 04H selects stopped 16-bit timer; 0CH also starts it.
`timescale 1ns/1ps
`include "tmr16_cfg.svh"
module tmr16_timer
   import tmr16_pkg::*;
   #(parameter int LF_DIV = `LF_DIV_DEFAULT,
     parameter int CNT_W = 16)
   (input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MATCH_OVERFLOW_INTERRUPT,
    output logic PWM_OUTPUT_PIN);
   // High clock is 62.5 ns; the base divider rounds that to whole cycles.
   localparam int HF_DIV = int'(`HF_PER_NS / `CLK_PER_NS);
   // ************************************************************
   // Registers and decode
   // ************************************************************
   logic [7:0] upper_ctrl_q, lower_ctrl_q;
   logic [7:0] cmp_lo_q, cmp_hi_q, duty_lo_q, duty_hi_q;
   // Duty stages keep all 16 bits so byte reads work for any counter width.
   logic [15:0] shadow_q, active_q, cmp_val;
   logic [CNT_W-1:0] count_q;
   logic divider_source_select_q, slow_mode_q;
   logic irq_flag_q, ff_q, run_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q, pin_q;
   logic [11:0] hf_tick;
   logic lf_tick, lf8_tick;
   op_mode_t mode;
   logic setup, wr_en, rd_en, mapped;
   logic wr_uc, wr_lc, wr_clo, wr_chi, wr_dlo, wr_dhi, wr_sys, wr_stat;
   logic [2:0] clk_sel;
   logic src_tick, at_match, at_ovf, event_hit, running;
   logic [31:0] rd_mux;
   assign setup = PSEL && !PENABLE;
   assign wr_en = setup && PWRITE && PSTRB[0];
   assign rd_en = setup && !PWRITE;
   assign wr_uc = wr_en && (PADDR == `OFF_UPPER_CTRL);
   assign wr_lc = wr_en && (PADDR == `OFF_LOWER_CTRL);
   assign wr_clo = wr_en && (PADDR == `OFF_CMP_LOW);
   assign wr_chi = wr_en && (PADDR == `OFF_CMP_HIGH);
   assign wr_dlo = wr_en && (PADDR == `OFF_DUTY_LOW);
   assign wr_dhi = wr_en && (PADDR == `OFF_DUTY_HIGH);
   assign wr_sys = wr_en && (PADDR == `OFF_SYSCFG);
   assign wr_stat = wr_en && (PADDR == `OFF_STATUS);
   // Address decode; unmapped addresses answer with PSLVERR.
   always_comb
   begin
      mapped = 1'b1;
      if (PADDR == `OFF_LOWER_CTRL)
         rd_mux = {24'h000000, lower_ctrl_q};
      else if (PADDR == `OFF_UPPER_CTRL)
         rd_mux = {24'h000000, upper_ctrl_q};
      else if (PADDR == `OFF_CMP_LOW)
         rd_mux = {24'h000000, cmp_lo_q};
      else if (PADDR == `OFF_CMP_HIGH)
         rd_mux = {24'h000000, cmp_hi_q};
      // Duty reads give the active value, not the pending shadow.
      // active duty readback
      else if (PADDR == `OFF_DUTY_LOW)
         rd_mux = {24'h000000, active_q[7:0]};
      else if (PADDR == `OFF_DUTY_HIGH)
         rd_mux = {24'h000000, active_q[15:8]};
      else if (PADDR == `OFF_STATUS)
         rd_mux = {30'h00000000, ff_q, irq_flag_q};
      else if (PADDR == `OFF_COUNT)
         rd_mux = 32'(count_q);
      else if (PADDR == `OFF_SYSCFG)
         rd_mux = {30'h00000000, slow_mode_q, divider_source_select_q};
      else
      begin
         rd_mux = 32'h00000000;
         mapped = 1'b0;
      end
   end
   // Answer in the cycle after setup, so access phases last one cycle.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         prdata_q <= rd_en ? rd_mux : 32'h00000000;
      end
   end
   // ************************************************************
   // Mode and clock select
   // ************************************************************
   // run bit from upper control
   assign run_q = upper_ctrl_q[`UC_RUN_BIT];
   // mode field decodes 4 (timer) and 6 (PWM)
   always_comb
   begin
      if (upper_ctrl_q[2:0] == `MODE_TIMER16)
         mode = OP_TIMER;
      else if (upper_ctrl_q[2:0] == `MODE_PWM16)
         mode = OP_PWM;
      else
         mode = OP_STOPPED;
   end
   assign running = run_q && (mode != OP_STOPPED);
   assign clk_sel = lower_ctrl_q[`LC_CLK_LSB +: 3];
   always_comb
   begin
      case (clk_sel)
         3'h0: src_tick = (divider_source_select_q || slow_mode_q) ?
                          lf8_tick : hf_tick[11];
         3'h1: src_tick = !slow_mode_q && hf_tick[7];
         3'h2: src_tick = !slow_mode_q && hf_tick[5];
         3'h3: src_tick = !slow_mode_q && hf_tick[3];
         3'h4: src_tick = (mode == OP_PWM) && lf_tick;
         3'h5: src_tick = (mode == OP_PWM) && !slow_mode_q && hf_tick[1];
         3'h6: src_tick = (mode == OP_PWM) && !slow_mode_q && hf_tick[0];
         default: src_tick = 1'b0;
      endcase
   end
   tmr16_prescaler #(.HF_DIV(HF_DIV), .LF_DIV(LF_DIV)) u_presc
   (
      .clk(CLK),
      .rst_n(RST_N),
      .hf_tick(hf_tick),
      .lf_tick(lf_tick),
      .lf8_tick(lf8_tick)
   );
   // ************************************************************
   // Counter and events
   // ************************************************************
   // full-width compare and overflow
   assign cmp_val = {cmp_hi_q, cmp_lo_q};
   assign at_match = (count_q == cmp_val[CNT_W-1:0]);
   assign at_ovf = &count_q;
   assign event_hit = running && src_tick &&
                      ((mode == OP_TIMER) ? at_match : at_ovf);
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         count_q <= '0;
      else if (!running)
         count_q <= '0;
      else if (src_tick)
         count_q <= event_hit ? '0 : count_q + 1'b1;
   end
   // Control and compare registers; compare writes act at once.
   // compare has no shadow
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         upper_ctrl_q <= `RST_UPPER_CTRL;
         lower_ctrl_q <= `RST_LOWER_CTRL;
         cmp_lo_q <= 8'h00;
         cmp_hi_q <= 8'h00;
         divider_source_select_q <= 1'b0;
         slow_mode_q <= 1'b0;
      end
      else
      begin
         if (wr_uc)
            upper_ctrl_q <= PWDATA[7:0];
         if (wr_lc)
            lower_ctrl_q <= PWDATA[7:0];
         if (wr_clo)
            cmp_lo_q <= PWDATA[7:0];
         if (wr_chi)
            cmp_hi_q <= PWDATA[7:0];
         if (wr_sys)
         begin
            divider_source_select_q <= PWDATA[0];
            slow_mode_q <= PWDATA[1];
         end
      end
   end
   // Duty staging; a write racing the interrupt loses to the old shadow.
   // shadow then active duty
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         shadow_q <= '0;
         active_q <= '0;
      end
      else
      begin
         if (wr_dlo)
            shadow_q[7:0] <= PWDATA[7:0];
         if (wr_dhi)
            shadow_q[15:8] <= PWDATA[7:0];
         if (!running && (wr_dlo || wr_dhi))
            active_q <= wr_dlo ? {shadow_q[15:8], PWDATA[7:0]} :
                                 {PWDATA[7:0], shadow_q[7:0]};
         else if (running && (mode == OP_PWM) && event_hit)
            active_q <= shadow_q;
      end
   end
   // Flip-flop: loads on initial-bit writes while stopped, toggles in PWM.
   // initial level and reset clear
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         ff_q <= 1'b0;
      else if (wr_uc && !PWDATA[`UC_RUN_BIT] && !run_q)
         ff_q <= PWDATA[`UC_INIT_BIT];
      else if (wr_uc && PWDATA[`UC_RUN_BIT] && !run_q)
         ff_q <= PWDATA[`UC_INIT_BIT];
      else if (running && (mode == OP_PWM) && src_tick &&
               (at_ovf || count_q == active_q[CNT_W-1:0]))
         ff_q <= !ff_q;
   end
   // Sticky flag; a new event wins over a clear in the same cycle.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         irq_flag_q <= 1'b0;
      else if (event_hit)
         irq_flag_q <= 1'b1;
      else if (wr_stat && PWDATA[0])
         irq_flag_q <= 1'b0;
   end
   // Registered outputs: one-cycle interrupt pulse and inverted pin.
   // inverse pin drive
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         irq_q <= 1'b0;
         pin_q <= 1'b1;
      end
      else
      begin
         irq_q <= event_hit;
         pin_q <= !ff_q;
      end
   end
   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign MATCH_OVERFLOW_INTERRUPT = irq_q;
   assign PWM_OUTPUT_PIN = pin_q;
   // ************************************************************
   // Assertions
   // ************************************************************
   a_timer_clear: assert property (@(posedge CLK) disable iff (!RST_N)
      event_hit && mode == OP_TIMER |=> count_q == '0)
      else $error("Counter not cleared after compare match.");
   a_irq_follows: assert property (@(posedge CLK) disable iff (!RST_N)
      event_hit |=> MATCH_OVERFLOW_INTERRUPT)
      else $error("Interrupt did not follow the event.");
   a_pin_inverse: assert property (@(posedge CLK) disable iff (!RST_N)
      ##1 PWM_OUTPUT_PIN == !$past(ff_q))
      else $error("Pin is not the inverse of the flip-flop.");
   a_stop_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      !running && !wr_uc |=> $stable(ff_q))
      else $error("Flip-flop moved while stopped.");
   a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)
      running && src_tick && !event_hit |=> count_q == $past(count_q) + 1'b1)
      else $error("Counter did not step on source tick.");
   a_shadow_load: assert property (@(posedge CLK) disable iff (!RST_N)
      running && mode == OP_PWM && event_hit |=> active_q == $past(shadow_q))
      else $error("Active duty not loaded at interrupt.");
   a_duty_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      running && !event_hit |=> $stable(active_q))
      else $error("Active duty changed between interrupts.");
   a_run_decode: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_uc && PWDATA[7:0] == 8'h0C |=> running && mode == OP_TIMER)
      else $error("Writing 0CH did not start the timer.");
   a_reset_pin: assert property (@(posedge CLK)
      !RST_N |=> !ff_q && !irq_flag_q)
      else $error("Reset did not clear the flip-flop.");
endmodule

// [tb/tb_top.sv]
// Self-checking testbench for the cascaded timer and PWM generator.
`timescale 1ns/1ps
`include "tmr16_cfg.svh"
module tb_top
   import tmr16_pkg::*;
   ;
   // Short counter width keeps a PWM period to a few thousand cycles.
   localparam int CW = 8;
   localparam int LFD = 4;
   localparam int HF = 16;
   logic CLK;
   logic RST_N;
   logic PSEL;
   logic PENABLE;
   logic PWRITE;
   logic [11:0] PADDR;
   logic [31:0] PWDATA;
   logic [3:0] PSTRB;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic MATCH_OVERFLOW_INTERRUPT;
   logic PWM_OUTPUT_PIN;
   int err_total;
   int cmp_count;

   tmr16_timer #(.LF_DIV(LFD), .CNT_W(CW)) dut_u
      (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
       .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
       .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
       .MATCH_OVERFLOW_INTERRUPT(MATCH_OVERFLOW_INTERRUPT),
       .PWM_OUTPUT_PIN(PWM_OUTPUT_PIN));

   // ****************************************
   // Shared tasks
   // ****************************************

   // Compare one value and count the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h",
                  $time, msg, seen, exp);
      end
   endtask

   // Print the verdict and stop the run.
   task automatic close_out();
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One APB transfer; entered just after a rising edge, leaves after one.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= {24'h000000, d};
      PSTRB <= 4'hF;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 50);
      rd = PRDATA;
      er = PSLVERR;
      if (n >= 50)
         check(PREADY, 1'b1, "no ready");
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic wr8(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err, input string msg);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      check(r, exp, msg);
      check(e, exp_err, "slave error");
   endtask

   // Wait for the next interrupt pulse; count cycles and pin-low cycles.
   task automatic wait_irq(output int n, output int lows);
      n = 0;
      lows = 0;
      do
      begin
         @(posedge CLK);
         n++;
         if (PWM_OUTPUT_PIN === 1'b0)
            lows++;
      end
      while (MATCH_OVERFLOW_INTERRUPT !== 1'b1 && n < 20000);
      if (n >= 20000)
         check(MATCH_OVERFLOW_INTERRUPT, 1'b1, "no interrupt");
   endtask

   // ****************************************
   // Scenarios
   // ****************************************

   // Reset levels, then an access to a hole in the map.
   task automatic t_reset();
      check(PWM_OUTPUT_PIN, 1'b1, "pin after reset");
      check(MATCH_OVERFLOW_INTERRUPT, 1'b0, "irq after reset");
      rdchk(`OFF_UPPER_CTRL, `RST_UPPER_CTRL, 1'b0, "upper rst");
      rdchk(`OFF_LOWER_CTRL, `RST_LOWER_CTRL, 1'b0, "lower rst");
      rdchk(12'hFFC, 32'h0, 1'b1, "unmapped read");
   endtask

   // Interval timer over every source clock that a short run can afford.
   task automatic t_timer();
      int sel[4] = '{1, 2, 3, 0};
      int tick[4] = '{2048 * HF / 16, 512, 128, 8 * LFD};
      int n;
      int l;
      for (int i = 0; i < 4; i++)
      begin
         wr8(`OFF_SYSCFG, (i == 3) ? 8'h01 : 8'h00);
         wr8(`OFF_UPPER_CTRL, 8'h04);
         wr8(`OFF_LOWER_CTRL, 8'((sel[i] << 4) | 3));
         // no external input pulse is applied
         wr8(`OFF_CMP_LOW, 8'h02);
         wr8(`OFF_CMP_HIGH, 8'h00);
         wr8(`OFF_UPPER_CTRL, 8'h0C);
         rdchk(`OFF_UPPER_CTRL, 32'h0C, 1'b0, "run set");
         wait_irq(n, l);
         wait_irq(n, l);
         check(n, 3 * tick[i], "timer period");
         check(PWM_OUTPUT_PIN, 1'b1, "pin idle in timer");
      end
      wr8(`OFF_UPPER_CTRL, 8'h04);
      // Sticky flag stays set after stopping until software clears it.
      rdchk(`OFF_STATUS, 32'h1, 1'b0, "irq flag set");
      wr8(`OFF_STATUS, 8'h01);
      rdchk(`OFF_STATUS, 32'h0, 1'b0, "irq flag clear");
      wr8(`OFF_SYSCFG, 8'h00);
   endtask

   // PWM with duty buffering, period and pulse width.
   task automatic t_pwm();
      int n;
      int l;
      logic p;
      wr8(`OFF_LOWER_CTRL, 8'h63);
      wr8(`OFF_UPPER_CTRL, 8'h06);
      // port latch is outside the block
      wr8(`OFF_DUTY_LOW, 8'h40);
      wr8(`OFF_DUTY_HIGH, 8'h00);
      rdchk(`OFF_DUTY_LOW, 32'h40, 1'b0, "stopped duty");
      wr8(`OFF_UPPER_CTRL, 8'h0E);
      wait_irq(n, l);
      wait_irq(n, l);
      check(n, (1 << CW) * HF, "pwm period");
      check(l, (255 - 8'h40) * HF, "low width");
      wr8(`OFF_DUTY_LOW, 8'h80);
      wr8(`OFF_DUTY_HIGH, 8'h00);
      rdchk(`OFF_DUTY_LOW, 32'h40, 1'b0, "old duty read");
      wait_irq(n, l);
      rdchk(`OFF_DUTY_LOW, 32'h80, 1'b0, "shifted duty");
      wait_irq(n, l);
      check(l, (255 - 8'h80) * HF, "new low width");
      repeat (1000) @(posedge CLK);
      wr8(`OFF_UPPER_CTRL, 8'h06);
      p = PWM_OUTPUT_PIN;
      repeat (300) @(posedge CLK);
      check(PWM_OUTPUT_PIN, p, "held on stop");
      wr8(`OFF_UPPER_CTRL, 8'h86);
      repeat (3) @(posedge CLK);
      check(PWM_OUTPUT_PIN, 1'b0, "init bit set");
      wr8(`OFF_UPPER_CTRL, 8'h06);
      repeat (3) @(posedge CLK);
      check(PWM_OUTPUT_PIN, 1'b1, "init bit clear");
   endtask

   // ****************************************
   // Clock, reset, sequence and watchdog
   // ****************************************

   // Free-running 250 MHz clock.
   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   // Main sequence; reset is held for ten cycles first.
   initial
   begin
      err_total = 0;
      cmp_count = 0;
      RST_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      PSTRB = 4'h0;
      repeat (10) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      t_reset();
      t_timer();
      t_pwm();
      close_out();
   end

   // A hang is cut short well past the expected run length.
   initial
   begin
      #280000;
      err_total++;
      close_out();
   end
endmodule
